// ===== hdl/usr_regs.vh
`ifndef USR_REGS_VH
`define USR_REGS_VH
// Status word bit positions
`define USR_BIT_TX_HOLD_EMPTY 7
`define USR_BIT_TX_SHIFT_EMPTY 6
`define USR_BIT_PERIPH_EDGE 5
`define USR_BIT_EXT_LEVEL 4
`define USR_BIT_FRAMING_ERR 3
`define USR_BIT_PARITY_ERR 2
`define USR_BIT_OVERRUN 1
`define USR_BIT_RX_DATA_AVAIL 0
// Reset value: transmit side empty, all else clear
`define USR_STATUS_RESET 8'hC0
`define USR_STATUS_W 8
`endif

// ===== hdl/usr_status.v
`timescale 1ns/1ps
`include "usr_regs.vh"
// Function
// RL1: Eight-bit status word: hold-empty 7, shift-empty 6, edge 5, level 4, errors, data 0.
// RL2: Hold-empty and data-available pins are inverted copies of their bits.
// RL3: Framing error set when stop bit low; refreshed on each holding-register load.
// RL4: Framing error also driven active high on its own pin.
// RL5: One shared pin shows parity error OR overrun error.
// RL6: Overrun set when new character loads while data-available still set.
// RL7: Data-available set once a full character loads into holding register.
// RL8: External-level bit set while external status input is low.
// RL9: Peripheral input falling edge sets edge bit; interrupt low when enabled.
// RL10: Clear input low clears status, interrupt flop and holding register state.
// RL11: Shift-empty set when shift register idle, cleared when a character loads.
module usr_status (
    input wire mclk, // System clock, 100 MHz
    input wire rst_n, // Async reset, active low
    input wire clear_n, // Synchronous clear input, active low
    input wire rx_load, // Pulse: character moved to receive holding register
    input wire rx_stop_bit, // Sampled stop bit level with rx_load
    input wire rx_parity_bad, // Parity check failed, valid with rx_load
    input wire rx_data_read, // Pulse: processor read of receive data
    input wire status_read, // Pulse: processor read of status word
    input wire tx_hold_load, // Pulse: processor wrote holding register
    input wire tx_shift_load, // Pulse: holding moved into shift register
    input wire tx_shift_done, // Pulse: shift register finished last stop bit
    input wire int_enable, // Interrupt enable from control register
    input wire periph_status_in, // Peripheral edge input, async pin
    input wire ext_status_in, // External level input, async pin
    output reg [7:0] status_word, // Status word to receive bus
    output reg tx_hold_empty_n, // Hold-empty pin, active low
    output reg rx_data_avail_n, // Data-available pin, active low
    output reg framing_err_pin, // Framing error pin, active high
    output reg parity_overrun_pin, // Parity or overrun pin, active high
    output reg int_n // Peripheral interrupt, active low
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    wire [1:0] pins_s;
    reg periph_prev_q;
    wire periph_fall;

    usr_sync #(
        .W(2)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({periph_status_in, ext_status_in}),
        .rst_val(2'h3),
        .q(pins_s)
    );

    // Edge detect works on the synchronised copy only
    assign periph_fall = periph_prev_q & ~pins_s[1];

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    reg tx_hold_empty_q, tx_shift_empty_q, periph_edge_q, ext_level_q;
    reg framing_err_q, parity_err_q, overrun_q, rx_data_avail_q, int_q;

    // Set-wins flag update; a clear in the same cycle as its event is lost
    function set_wins;
        input cur;
        input set;
        input clr;
        begin
            if (set)
                set_wins = 1'b1;
            else if (clr)
                set_wins = 1'b0;
            else
                set_wins = cur;
        end
    endfunction

    // Previous synchronised peripheral level; tracks the pin even during clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            periph_prev_q <= 1'b1;
        end else begin
            periph_prev_q <= pins_s[1];
        end
    end

    // Level input, no latching; three edges behind the pin [RL8]
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_level_q <= 1'b0;
        end else if (!clear_n) begin
            ext_level_q <= 1'b0; // [RL10]
        end else begin
            ext_level_q <= ~pins_s[0]; // [RL8]
        end
    end

    // Hold register empties when moved to shifter; the move beats a new write
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_empty_q <= 1'b1;
        end else if (!clear_n) begin
            tx_hold_empty_q <= 1'b1; // [RL10]
        end else begin
            tx_hold_empty_q <= set_wins(tx_hold_empty_q, tx_shift_load, tx_hold_load);
        end
    end

    // Shift empty follows shifter occupancy; load wins over done [RL11]
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_empty_q <= 1'b1;
        end else if (!clear_n) begin
            tx_shift_empty_q <= 1'b1; // [RL10]
        end else if (tx_shift_load) begin
            tx_shift_empty_q <= 1'b0; // [RL11]
        end else if (tx_shift_done) begin
            tx_shift_empty_q <= 1'b1; // [RL11]
        end
    end

    // Receive side errors refreshed on each load, not sticky [RL3]
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            framing_err_q <= 1'b0;
            parity_err_q <= 1'b0;
        end else if (!clear_n) begin
            framing_err_q <= 1'b0; // [RL10]
            parity_err_q <= 1'b0;
        end else if (rx_load) begin
            framing_err_q <= ~rx_stop_bit; // [RL3]
            parity_err_q <= rx_parity_bad;
        end
    end

    // Overrun looks at the flag before this load; a read in the same cycle is too late
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_q <= 1'b0;
        end else if (!clear_n) begin
            overrun_q <= 1'b0; // [RL10]
        end else if (rx_load) begin
            overrun_q <= rx_data_avail_q; // [RL6]
        end
    end

    // Data available: load sets, data read clears, load wins [RL7]
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_avail_q <= 1'b0;
        end else if (!clear_n) begin
            rx_data_avail_q <= 1'b0; // [RL10]
        end else begin
            rx_data_avail_q <= set_wins(rx_data_avail_q, rx_load, rx_data_read); // [RL7]
        end
    end

    // Edge bit and interrupt: edge sets win over a clearing status read [RL9]
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            periph_edge_q <= 1'b0;
            int_q <= 1'b0;
        end else if (!clear_n) begin
            periph_edge_q <= 1'b0; // [RL10]
            int_q <= 1'b0;
        end else begin
            periph_edge_q <= set_wins(periph_edge_q, periph_fall, status_read); // [RL9]
            int_q <= set_wins(int_q, periph_fall & int_enable, status_read); // [RL9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs; one cycle behind the flags, no combinational path
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_word <= `USR_STATUS_RESET;
            tx_hold_empty_n <= 1'b0;
            rx_data_avail_n <= 1'b1;
            framing_err_pin <= 1'b0;
            parity_overrun_pin <= 1'b0;
            int_n <= 1'b1;
        end else begin
            status_word[`USR_BIT_TX_HOLD_EMPTY] <= tx_hold_empty_q; // [RL1]
            status_word[`USR_BIT_TX_SHIFT_EMPTY] <= tx_shift_empty_q;
            status_word[`USR_BIT_PERIPH_EDGE] <= periph_edge_q;
            status_word[`USR_BIT_EXT_LEVEL] <= ext_level_q;
            status_word[`USR_BIT_FRAMING_ERR] <= framing_err_q;
            status_word[`USR_BIT_PARITY_ERR] <= parity_err_q;
            status_word[`USR_BIT_OVERRUN] <= overrun_q;
            status_word[`USR_BIT_RX_DATA_AVAIL] <= rx_data_avail_q;
            tx_hold_empty_n <= ~tx_hold_empty_q; // [RL2]
            rx_data_avail_n <= ~rx_data_avail_q; // [RL2] [RL7]
            framing_err_pin <= framing_err_q; // [RL4]
            parity_overrun_pin <= parity_err_q | overrun_q; // [RL5]
            int_n <= ~int_q; // [RL9]
        end
    end
endmodule

// ===== hdl/usr_sync.v
`timescale 1ns/1ps
module usr_sync #(
    parameter W = 2
) (
    input wire mclk, // Clock
    input wire rst_n, // Async reset, active low
    input wire [W-1:0] d, // Asynchronous levels
    input wire [W-1:0] rst_val, // Unused for flops, reset is constant ones
    output reg [W-1:0] q // Synchronised levels
);
    reg [W-1:0] meta_q;

    // Two stages; first stage feeds only the second
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b1}};
            q <= {W{1'b1}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== verif/test_uart_status_register.sv
`timescale 1ns/1ps
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("Error %0t: %h", $time, a); end end
module test_uart_status_register;
logic mclk = 0, rst_n = 0, clear_n = 1, stop = 1, par = 0, ie = 1, periph_edge_status = 1, es = 1;
logic [3:0] pv = 0;
logic [1:0] req = 0;
wire [7:0] sw;
wire hold_n, avail_n, fe, pe_oe, int_n, drd, srd;
int err_count = 0, cmp_count = 0;
usr_cpu_model u_cpu (.mclk(mclk), .req(req), .rx_data_read(drd), .status_read(srd));
usr_status u_dut (.mclk(mclk), .rst_n(rst_n), .clear_n(clear_n), .rx_load(pv[3]),
    .rx_stop_bit(stop), .rx_parity_bad(par), .rx_data_read(drd), .status_read(srd),
    .tx_hold_load(pv[2]), .tx_shift_load(pv[1]), .tx_shift_done(pv[0]), .int_enable(ie),
    .periph_status_in(periph_edge_status), .ext_status_in(es), .status_word(sw), .tx_hold_empty_n(hold_n),
    .rx_data_avail_n(avail_n), .framing_err_pin(fe), .parity_overrun_pin(pe_oe), .int_n(int_n));
initial forever #5 mclk = ~mclk;
// One strobe cycle, then enough settling for the slowest path (pins)
task go(input [3:0] v, input [1:0] r);
    pv = v;
    req = r;
    @(negedge mclk);
    pv = 0;
    req = 0;
    repeat (6) @(negedge mclk);
endtask
task t_reset;
    `CK(sw, 8'hC0)
    `CK({hold_n, avail_n, fe, pe_oe, int_n}, 5'b01001)
    $display("t_reset done");
endtask
// Second character before the read must flag overrun
task t_rx;
    stop = 0;
    go(4'h8, 0);
    `CK(sw, 8'hC9)
    `CK({avail_n, fe}, 2'b01)
    stop = 1;
    par = 1;
    go(4'h8, 0);
    `CK(sw, 8'hC7)
    `CK({pe_oe, fe}, 2'b10)
    par = 0;
    go(0, 2'b10);
    `CK({sw[0], avail_n}, 2'b01)
    $display("t_rx done");
endtask
task t_tx;
    go(4'h4, 0);
    `CK({sw[7:6], hold_n}, 3'b011)
    go(4'h2, 0);
    `CK({sw[7:6], hold_n}, 3'b100)
    go(4'h1, 0);
    `CK(sw[6], 1'b1)
    $display("t_tx done");
endtask
task t_ext;
    es = 0;
    go(0, 0);
    `CK(sw[4], 1'b1)
    es = 1;
    periph_edge_status = 0;
    go(0, 0);
    `CK({sw[5], int_n}, 2'b10)
    periph_edge_status = 1;
    go(0, 2'b01);
    `CK({sw[5], int_n}, 2'b01)
    ie = 0;
    periph_edge_status = 0;
    go(0, 0);
    `CK({sw[5], int_n}, 2'b11)
    periph_edge_status = 1;
    ie = 1;
    go(0, 2'b01);
    `CK({sw[5], int_n}, 2'b01)
    $display("t_ext done");
endtask
// A load during clear is ignored
task t_clear;
    go(4'h8, 0);
    clear_n = 0;
    go(4'h8, 0);
    `CK(sw, 8'hC0)
    clear_n = 1;
    $display("t_clear done");
endtask
task test_done;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1;
    @(negedge mclk);
    t_reset;
    t_rx;
    t_tx;
    t_ext;
    t_clear;
    test_done;
end
endmodule

// ===== verif/usr_cpu_model.sv
`timescale 1ns/1ps
module usr_cpu_model (
    input wire mclk, // Clock
    input wire [1:0] req, // Bench request: data read, status read
    output reg rx_data_read, // Data read strobe
    output reg status_read // Status read strobe
);
// Strobes follow a request by one cycle and last as long as the request is held
// Taken on the rising edge so the bench's falling-edge request never races the model
initial {rx_data_read, status_read} = 2'b00;
always @(posedge mclk) begin
    {rx_data_read, status_read} <= req;
end
endmodule

// ===== verif/usr_status_assertions.sv
`timescale 1ns/1ps
module usr_status_assertions (
    input wire mclk, rst_n, clear_n, rx_load, rx_stop_bit, rx_data_read, ext_status_in, // In
    input wire [7:0] status_word, // Word
    input wire tx_hold_empty_n, framing_err_pin, parity_overrun_pin // Pins
);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
// Pins and word come from the same flags, so they must agree every cycle
a_hold_pin_inv: assert property (tx_hold_empty_n != status_word[7])
    else $error("hold pin");
a_frame_pin_copy: assert property (framing_err_pin == status_word[3])
    else $error("frame pin");
a_err_pin_or: assert property (parity_overrun_pin == |status_word[2:1])
    else $error("error pin");
// Loads show two edges later; a read in the load cycle loses
a_load_sets_avail: assert property (rx_load && clear_n |-> ##2 status_word[0])
    else $error("avail");
a_load_frame: assert property (rx_load && clear_n |-> ##2 status_word[3] != $past(rx_stop_bit, 2))
    else $error("frame");
a_load_overrun: assert property ((clear_n && !rx_data_read) ##1 (rx_load && clear_n && status_word[0]) |-> ##2 status_word[1])
    else $error("overrun");
a_clear_flags: assert property (!clear_n |-> ##2 {status_word[7:5], status_word[3:0]} == 7'h60)
    else $error("clear");
// Level pin passes a two-flop synchroniser first
a_ext_level: assert property ((!ext_status_in && clear_n) [*5] |-> status_word[4])
    else $error("ext level");
endmodule
bind usr_status usr_status_assertions u_chk (.*);
